// ---- verilog/scu_pkg.sv ----
// Shared constants and types of the conditional-store unit.
package scu_pkg;

  // ----------------------------------------
  // Register map of the plain register port
  // ----------------------------------------
  localparam logic [3:0] CFG_OFS = 4'h0;
  localparam logic [3:0] STAT_OFS = 4'h4;
  localparam logic [3:0] LADDR_OFS = 4'h8;
  localparam int CFG_ULS_BIT = 0;
  localparam int CFG_EVA_BIT = 1;
  localparam int CFG_XNP_BIT = 2;
  localparam logic [2:0] CFG_RST = 3'h3;
  localparam int STAT_FLAG_BIT = 0;
  localparam int STAT_BUSY_BIT = 1;

  // ----------------------------------------
  // Datapath figures
  // ----------------------------------------
  localparam int ADDR_W = 32;
  localparam int WORD_W = 32;
  localparam int IMM_W_NOW = 9;
  localparam int IMM_W_OLD = 16;
  localparam int BLOCK_LG_DEF = 4;
  localparam logic [31:0] RES_OK = 32'h0000_0001;
  localparam logic [31:0] RES_FAIL = 32'h0000_0000;
  localparam logic [31:0] HI_WORD_OFS = 32'h0000_0004;

  // ----------------------------------------
  // Enumerations
  // ----------------------------------------
  typedef enum logic [1:0] {
    KIND_BASIC = 2'h0,
    KIND_USER = 2'h1,
    KIND_PAIR = 2'h2
  } scu_kind_e;

  typedef enum logic [2:0] {
    EXC_NONE = 3'h0,
    EXC_TLB_REFILL = 3'h1,
    EXC_TLB_INVALID = 3'h2,
    EXC_TLB_MOD = 3'h3,
    EXC_WATCH = 3'h4,
    EXC_ADDR_ERR = 3'h5,
    EXC_RSVD_INSTR = 3'h6,
    EXC_COP_UNUSABLE = 3'h7
  } scu_exc_e;

  // Gray codes along idle, translate, write low, write high, finish.
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_XLAT = 3'h1,
    ST_WR_LO = 3'h3,
    ST_WR_HI = 3'h2,
    ST_DONE = 3'h6,
    ST_MON = 3'h7
  } scu_state_e;

endpackage

// ---- verilog/scu_link_tracker.sv ----
// Link flag and linked address held between a linked load and a conditional store.
module scu_link_tracker #(
  parameter int BLOCK_LG = scu_pkg::BLOCK_LG_DEF,
  parameter bit HAS_LINK_ADDR = 1'b1
) (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic ll_valid,
  input wire logic [31:0] ll_paddr,
  input wire logic exception_return_evt,
  input wire logic exc_evt,
  input wire logic remote_store_valid,
  input wire logic [31:0] remote_store_paddr,
  input wire logic consume,
  output logic link_valid_flag,
  output logic [31:0] link_addr_reg
);

  logic remote_hit;

  // A remote coherent store hits when it falls in the watched block.
  assign remote_hit = remote_store_valid &&
    (remote_store_paddr[31:BLOCK_LG] == link_addr_reg[31:BLOCK_LG]);

  // Flag is set by any linked load; the set wins over every clearing event.
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      link_valid_flag <= 1'b0;
    end else if (ll_valid) begin
      link_valid_flag <= 1'b1;
    end else if (exception_return_evt || exc_evt || remote_hit || consume) begin
      link_valid_flag <= 1'b0;
    end
  end

  // Linked address is kept only when the option is built in.
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      link_addr_reg <= 32'h0000_0000;
    end else if (ll_valid && HAS_LINK_ADDR) begin
      link_addr_reg <= ll_paddr;
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);

  AST_EXCEPTION_RETURN_CLEARS: assert property (exception_return_evt && !ll_valid |=> !link_valid_flag)
    else $error("Exception return left the link flag set.");
  AST_EXC_CLEARS: assert property (exc_evt && !ll_valid |=> !link_valid_flag)
    else $error("Exception left the link flag set.");
  AST_REMOTE_CLEARS: assert property (remote_hit && !ll_valid |=> !link_valid_flag)
    else $error("Remote store into the watched block left the link flag set.");
  AST_LL_SETS: assert property (ll_valid |=> link_valid_flag)
    else $error("Linked load did not set the link flag.");

endmodule // scu_link_tracker

// ---- verilog/scu_cond_store.sv ----
// Conditional-store execution unit with its register port.
module scu_cond_store #(
  parameter int IMM_W = scu_pkg::IMM_W_NOW,
  parameter int BLOCK_LG = scu_pkg::BLOCK_LG_DEF,
  parameter bit HAS_LINK_ADDR = 1'b1
) (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic [3:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire logic ll_valid,
  input wire logic [31:0] ll_paddr,
  input wire logic exception_return_evt,
  input wire logic exc_evt,
  input wire logic remote_store_valid,
  input wire logic [31:0] remote_store_paddr,
  input wire logic cs_req,
  input wire logic [1:0] cs_kind,
  input wire logic [31:0] cs_base,
  input wire logic [IMM_W-1:0] cs_imm,
  input wire logic [31:0] cs_src,
  input wire logic [31:0] cs_hi,
  input wire logic cs_cop_unusable,
  output logic xlat_req,
  output logic [31:0] xlat_vaddr,
  output logic xlat_user_map,
  input wire logic xlat_ack,
  input wire logic [31:0] xlat_paddr,
  input wire logic xlat_uncached,
  input wire logic [2:0] xlat_exc,
  output logic mem_wr_valid,
  output logic [31:0] mem_wr_addr,
  output logic [31:0] mem_wr_data,
  output logic mem_wr_lock,
  input wire logic mem_wr_ack,
  output logic mon_req,
  output logic mon_pair,
  input wire logic mon_resp_valid,
  input wire logic mon_resp_ok,
  output logic res_valid,
  output logic [31:0] res_value,
  output logic [2:0] res_exc
);

  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  scu_pkg::scu_state_e state_ff;
  scu_pkg::scu_state_e nxt_state;
  logic [2:0] cfg_ff;
  logic [1:0] kind_ff;
  logic [31:0] src_ff;
  logic [31:0] hi_ff;
  logic [31:0] paddr_ff;
  logic link_flag;
  logic [31:0] link_addr;
  logic consume;
  logic [31:0] ea;
  logic [2:0] pre_exc;
  logic link_ok;
  logic is_pair;

  // Effective address: base plus sign-extended immediate, or base alone when paired.
  function automatic logic [31:0] calc_ea(input logic [1:0] kind, input logic [31:0] base,
                                          input logic [IMM_W-1:0] imm);
    logic [31:0] ext;
    ext = {{(32 - IMM_W){imm[IMM_W-1]}}, imm};
    if (kind == scu_pkg::KIND_PAIR) begin
      calc_ea = base;
    end else begin
      calc_ea = base + ext;
    end
  endfunction

  // Aligned address compare: word alignment, or double-word alignment for the paired form.
  function automatic logic addr_match(input logic pair, input logic [31:0] a, input logic [31:0] b);
    if (pair) begin
      addr_match = (a[31:3] == b[31:3]);
    end else begin
      addr_match = (a[31:2] == b[31:2]);
    end
  endfunction

  // ----------------------------------------
  // Link state
  // ----------------------------------------
  scu_link_tracker #(
    .BLOCK_LG(BLOCK_LG),
    .HAS_LINK_ADDR(HAS_LINK_ADDR)
  ) u_link (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .ll_valid(ll_valid),
    .ll_paddr(ll_paddr),
    .exception_return_evt(exception_return_evt),
    .exc_evt(exc_evt),
    .remote_store_valid(remote_store_valid),
    .remote_store_paddr(remote_store_paddr),
    .consume(consume),
    .link_valid_flag(link_flag),
    .link_addr_reg(link_addr)
  );

  // A finished store consumes the link; local loads never touch it.
  assign consume = (state_ff == scu_pkg::ST_DONE);

  // ----------------------------------------
  // Request decode
  // ----------------------------------------
  assign ea = calc_ea(cs_kind, cs_base, cs_imm);
  assign is_pair = (kind_ff == scu_pkg::KIND_PAIR);

  // Outcome of the link check: flag and address only, whatever load set them.
  assign link_ok = link_flag && (!HAS_LINK_ADDR || addr_match(is_pair, xlat_paddr, link_addr));

  // Exceptions found before translation, in priority order.
  always_comb begin
    pre_exc = scu_pkg::EXC_NONE;
    if (cs_kind == scu_pkg::KIND_USER && !cfg_ff[scu_pkg::CFG_EVA_BIT]) begin
      pre_exc = scu_pkg::EXC_RSVD_INSTR;
    end else if (cs_kind == scu_pkg::KIND_PAIR && cfg_ff[scu_pkg::CFG_XNP_BIT]) begin
      pre_exc = scu_pkg::EXC_RSVD_INSTR;
    end else if (cs_kind > scu_pkg::KIND_PAIR) begin
      pre_exc = scu_pkg::EXC_RSVD_INSTR;
    end else if (cs_kind == scu_pkg::KIND_USER && cs_cop_unusable) begin
      pre_exc = scu_pkg::EXC_COP_UNUSABLE;
    end else if (cs_kind != scu_pkg::KIND_PAIR && ea[1:0] != 2'h0) begin
      pre_exc = scu_pkg::EXC_ADDR_ERR;
    end
  end

  // ----------------------------------------
  // Sequencer
  // ----------------------------------------
  // Next state of the store sequence.
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      scu_pkg::ST_IDLE: begin
        if (cs_req) begin
          nxt_state = (pre_exc != scu_pkg::EXC_NONE) ? scu_pkg::ST_DONE : scu_pkg::ST_XLAT;
        end
      end
      scu_pkg::ST_XLAT: begin
        if (xlat_ack) begin
          if (xlat_exc != scu_pkg::EXC_NONE || !link_ok) begin
            nxt_state = scu_pkg::ST_DONE;
          end else if (xlat_uncached) begin
            nxt_state = cfg_ff[scu_pkg::CFG_ULS_BIT] ? scu_pkg::ST_MON : scu_pkg::ST_DONE;
          end else begin
            nxt_state = scu_pkg::ST_WR_LO;
          end
        end
      end
      scu_pkg::ST_WR_LO: begin
        if (mem_wr_ack) begin
          nxt_state = is_pair ? scu_pkg::ST_WR_HI : scu_pkg::ST_DONE;
        end
      end
      scu_pkg::ST_WR_HI: begin
        if (mem_wr_ack) begin
          nxt_state = scu_pkg::ST_DONE;
        end
      end
      scu_pkg::ST_MON: begin
        if (mon_resp_valid) begin
          nxt_state = scu_pkg::ST_DONE;
        end
      end
      scu_pkg::ST_DONE: begin
        nxt_state = scu_pkg::ST_IDLE;
      end
      default: begin
        nxt_state = scu_pkg::ST_IDLE;
      end
    endcase
  end

  // State register.
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      state_ff <= scu_pkg::ST_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // Operands captured when a request is taken.
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      kind_ff <= 2'h0;
      src_ff <= 32'h0000_0000;
      hi_ff <= 32'h0000_0000;
    end else if (state_ff == scu_pkg::ST_IDLE && cs_req) begin
      kind_ff <= cs_kind;
      src_ff <= cs_src;
      hi_ff <= cs_hi;
    end
  end

  // Translation request, held until acknowledged.
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      xlat_req <= 1'b0;
      xlat_vaddr <= 32'h0000_0000;
      xlat_user_map <= 1'b0;
    end else if (state_ff == scu_pkg::ST_IDLE && cs_req && pre_exc == scu_pkg::EXC_NONE) begin
      xlat_req <= 1'b1;
      xlat_vaddr <= (cs_kind == scu_pkg::KIND_PAIR) ? {ea[31:3], 3'h0} : ea;
      xlat_user_map <= (cs_kind == scu_pkg::KIND_USER);
    end else if (xlat_ack) begin
      xlat_req <= 1'b0;
    end
  end

  // Physical address captured from the translation answer; the write port does not read it.
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      paddr_ff <= 32'h0000_0000;
    end else if (state_ff == scu_pkg::ST_XLAT && xlat_ack) begin
      paddr_ff <= xlat_paddr;
    end
  end

  // Memory write port: low word first, then high word, both under the lock when paired.
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      mem_wr_valid <= 1'b0;
      mem_wr_addr <= 32'h0000_0000;
      mem_wr_data <= 32'h0000_0000;
      mem_wr_lock <= 1'b0;
    end else if (nxt_state == scu_pkg::ST_WR_LO && state_ff == scu_pkg::ST_XLAT) begin
      mem_wr_valid <= 1'b1;
      mem_wr_addr <= is_pair ? {xlat_paddr[31:3], 3'h0} : xlat_paddr;
      mem_wr_data <= src_ff;
      mem_wr_lock <= is_pair;
    end else if (nxt_state == scu_pkg::ST_WR_HI && state_ff == scu_pkg::ST_WR_LO) begin
      mem_wr_addr <= mem_wr_addr + scu_pkg::HI_WORD_OFS;
      mem_wr_data <= hi_ff;
    end else if (mem_wr_ack) begin
      mem_wr_valid <= 1'b0;
      mem_wr_lock <= 1'b0;
    end
  end

  // With the ULS bit set, an uncached store goes to the outside monitor, which owns the outcome.
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      mon_req <= 1'b0;
      mon_pair <= 1'b0;
    end else if (nxt_state == scu_pkg::ST_MON && state_ff == scu_pkg::ST_XLAT) begin
      mon_req <= 1'b1;
      mon_pair <= is_pair;
    end else if (mon_resp_valid) begin
      mon_req <= 1'b0;
    end
  end

  // Result for the source register, or the exception taken instead.
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      res_valid <= 1'b0;
      res_value <= scu_pkg::RES_FAIL;
      res_exc <= scu_pkg::EXC_NONE;
    end else begin
      res_valid <= (nxt_state == scu_pkg::ST_DONE);
      if (state_ff == scu_pkg::ST_IDLE && cs_req) begin
        res_exc <= pre_exc;
        res_value <= scu_pkg::RES_FAIL;
      end else if (state_ff == scu_pkg::ST_XLAT && xlat_ack) begin
        res_exc <= xlat_exc;
        res_value <= scu_pkg::RES_FAIL;
      end else if (nxt_state == scu_pkg::ST_DONE && state_ff == scu_pkg::ST_MON) begin
        res_value <= {31'h0000_0000, mon_resp_ok};
      end else if (nxt_state == scu_pkg::ST_DONE && mem_wr_ack) begin
        res_value <= scu_pkg::RES_OK;
      end
    end
  end

  // ----------------------------------------
  // Register port
  // ----------------------------------------
  // Configuration fields steer which forms and memory types are honoured.
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      cfg_ff <= scu_pkg::CFG_RST;
    end else if (reg_wr && reg_addr == scu_pkg::CFG_OFS) begin
      cfg_ff <= reg_wdata[2:0];
    end
  end

  // Read data stand in the cycle after the strobe; unmapped offsets read zero.
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      reg_rdata <= 32'h0000_0000;
    end else if (reg_rd) begin
      case (reg_addr)
        scu_pkg::CFG_OFS: reg_rdata <= {29'h0000_0000, cfg_ff};
        scu_pkg::STAT_OFS: reg_rdata <= {30'h0000_0000, state_ff != scu_pkg::ST_IDLE, link_flag};
        scu_pkg::LADDR_OFS: reg_rdata <= link_addr;
        default: reg_rdata <= 32'h0000_0000;
      endcase
    end else begin
      reg_rdata <= 32'h0000_0000;
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);

  AST_RES_LOW_BIT: assert property (res_valid |-> res_value[31:1] == 31'h0000_0000)
    else $error("Result has bits set above bit zero.");
  AST_NO_WRITE_BROKEN: assert property (
    state_ff == scu_pkg::ST_XLAT && xlat_ack && !link_ok |=> !mem_wr_valid && res_valid && res_value == 32'h0)
    else $error("Broken sequence wrote memory or reported success.");
  AST_ALIGN_ERR: assert property (
    state_ff == scu_pkg::ST_IDLE && cs_req && cs_kind == scu_pkg::KIND_BASIC && ea[1:0] != 2'h0
    |=> res_valid && res_exc == scu_pkg::EXC_ADDR_ERR && !xlat_req)
    else $error("Misaligned word store raised no address error.");
  AST_SUCCESS_ONE: assert property (
    state_ff == scu_pkg::ST_WR_LO && mem_wr_ack && !is_pair |=> res_valid && res_value == 32'h1)
    else $error("Completed word store did not return one.");
  AST_PAIR_HIGH: assert property (
    state_ff == scu_pkg::ST_WR_LO && mem_wr_ack && is_pair |=> mem_wr_valid && mem_wr_lock
    && mem_wr_data == hi_ff && mem_wr_addr[2:0] == 3'h4)
    else $error("Paired high word not written at the upper half.");
  AST_USER_NEEDS_EXT: assert property (
    state_ff == scu_pkg::ST_IDLE && cs_req && cs_kind == scu_pkg::KIND_USER && !cfg_ff[scu_pkg::CFG_EVA_BIT]
    |=> res_exc == scu_pkg::EXC_RSVD_INSTR)
    else $error("User-space form ran while disabled.");
  AST_PAIR_NEEDS_PRESENT: assert property (
    state_ff == scu_pkg::ST_IDLE && cs_req && cs_kind == scu_pkg::KIND_PAIR && cfg_ff[scu_pkg::CFG_XNP_BIT]
    |=> res_exc == scu_pkg::EXC_RSVD_INSTR)
    else $error("Paired form ran while absent.");
  AST_UNCACHED_NOT_LOCAL: assert property (
    state_ff == scu_pkg::ST_XLAT && xlat_ack && xlat_exc == scu_pkg::EXC_NONE && xlat_uncached
    |=> !mem_wr_valid ##0 (mon_req || res_value == 32'h0))
    else $error("Uncached store succeeded without the monitor.");
  AST_USER_MAP: assert property (xlat_req |-> xlat_user_map == (kind_ff == scu_pkg::KIND_USER))
    else $error("Translation mapping does not match the store form.");

  COV_WORD_OK: cover property (state_ff == scu_pkg::ST_WR_LO && mem_wr_ack ##1 res_value == 32'h1);
  COV_PAIR_OK: cover property (state_ff == scu_pkg::ST_WR_HI && mem_wr_ack);
  COV_MON: cover property (mon_req && mon_resp_valid && mon_resp_ok);
  COV_FAIL: cover property (state_ff == scu_pkg::ST_XLAT && xlat_ack && !link_ok);

endmodule // scu_cond_store

// ---- tb/scu_far_model.sv ----
// Far-side model: address translation, cache write port and uncached monitor.
module scu_far_model (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic pm_slow,
  input wire logic pm_unc,
  input wire logic [2:0] pm_exc,
  input wire logic pm_ok,
  input wire logic xlat_req,
  input wire logic [31:0] xlat_vaddr,
  output logic xlat_ack,
  output logic [31:0] xlat_paddr,
  output logic xlat_uncached,
  output logic [2:0] xlat_exc,
  input wire logic mem_wr_valid,
  output logic mem_wr_ack,
  input wire logic mon_req,
  output logic mon_resp_valid,
  output logic mon_resp_ok
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] wait_ff;

  // Answers each pending request once, either at once or after three idle cycles.
  always_ff @(posedge core_clk) begin
    xlat_ack <= 1'b0;
    mem_wr_ack <= 1'b0;
    mon_resp_valid <= 1'b0;
    if (sys_rst || !(xlat_req || mem_wr_valid || mon_req)) begin
      wait_ff <= 2'h0;
    end else if (pm_slow && wait_ff != 2'h3) begin
      wait_ff <= wait_ff + 2'h1;
    end else if (!(xlat_ack || mem_wr_ack || mon_resp_valid)) begin
      wait_ff <= 2'h0;
      xlat_ack <= xlat_req;
      mem_wr_ack <= mem_wr_valid;
      mon_resp_valid <= mon_req;
    end
  end

  // Qualifiers mean something only beside an answer; otherwise they show junk.
  assign xlat_paddr = xlat_ack ? xlat_vaddr : ~xlat_vaddr;
  assign xlat_uncached = xlat_ack ? pm_unc : ~pm_unc;
  assign xlat_exc = xlat_ack ? pm_exc : ~pm_exc;
  assign mon_resp_ok = mon_resp_valid ? pm_ok : ~pm_ok;
endmodule // scu_far_model

// ---- tb/store_conditional_unit_tb.sv ----
// Self-checking bench of the conditional-store unit against its far side.
module store_conditional_unit_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic reg_wr = 1'b0, reg_rd = 1'b0, cs_req = 1'b0, cs_cop_unusable = 1'b0;
  logic ll_valid = 1'b0, exception_return_evt = 1'b0, exc_evt = 1'b0, remote_store_valid = 1'b0;
  logic [3:0] reg_addr = 4'h0;
  logic [1:0] cs_kind = 2'h0;
  logic [8:0] cs_imm = 9'h0;
  logic [31:0] reg_wdata = 32'h0, ll_paddr = 32'h0, remote_store_paddr = 32'h0;
  logic [31:0] cs_base = 32'h0, cs_src = 32'h0, cs_hi = 32'h0;
  logic pm_slow = 1'b0, pm_unc = 1'b0, pm_ok = 1'b0;
  logic [2:0] pm_exc = 3'h0;
  logic xlat_req, xlat_user_map, xlat_ack, xlat_uncached, mem_wr_valid, mem_wr_lock, mem_wr_ack;
  logic mon_req, mon_pair, mon_resp_valid, mon_resp_ok, res_valid, user_seen, pair_seen;
  logic [31:0] reg_rdata, xlat_vaddr, xlat_paddr, mem_wr_addr, mem_wr_data, res_value;
  logic [2:0] xlat_exc, res_exc;
  logic [64:0] wr_q[$];
  int miscompares = 0, tests_run = 0, mon_cnt = 0;

  scu_cond_store dut (.*);
  scu_far_model far (.*);

  // Free-running core clock.
  always #10 core_clk = ~core_clk;

  // Logs accepted memory writes, monitor hand-offs and the mapping used.
  always @(posedge core_clk) begin
    if (mem_wr_valid && mem_wr_ack) wr_q.push_back({mem_wr_lock, mem_wr_addr, mem_wr_data});
    if (mon_req && mon_resp_valid) mon_cnt++;
    if (xlat_req) user_seen = xlat_user_map;
    if (mon_req) pair_seen = mon_pair;
  end

  task automatic check(input string what, input logic [64:0] seen, input logic [64:0] exp);
    tests_run++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic complete_run();
    if (miscompares == 0 && tests_run > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic reg_write(input logic [3:0] a, input logic [31:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask

  task automatic reg_read(input logic [3:0] a, output logic [31:0] d);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    @(posedge core_clk);
    d = reg_rdata;
  endtask

  // Pulses one event: 0 linked load, 1 exception return, 2 exception, 3 remote store.
  task automatic ev(input int k, input logic [31:0] a);
    ll_valid <= (k == 0);
    exception_return_evt <= (k == 1);
    exc_evt <= (k == 2);
    remote_store_valid <= (k == 3);
    ll_paddr <= a;
    remote_store_paddr <= a;
    @(posedge core_clk);
    {ll_valid, exception_return_evt, exc_evt, remote_store_valid} <= 4'h0;
    @(posedge core_clk);
  endtask

  // Links (unless la is zero), injects event k (none when k is 4), stores and checks the outcome.
  task automatic trial(input int k, input logic [31:0] la, input logic [31:0] ea, input logic [1:0] kd,
                       input logic [31:0] b, input logic [8:0] i, input logic e, input logic [2:0] ex,
                       input int nw, input int nm);
    wr_q.delete();
    mon_cnt = 0;
    if (la != 32'h0) ev(0, la);
    ev(k, ea);
    cs_kind <= kd;
    cs_base <= b;
    cs_imm <= i;
    cs_src <= 32'h5A5A_C3C3;
    cs_hi <= 32'hA5A5_3C3C;
    cs_req <= 1'b1;
    @(posedge core_clk);
    cs_req <= 1'b0;
    for (int n = 0; n < 40 && res_valid !== 1'b1; n++) @(posedge core_clk);
    check("result", res_value, {31'h0, e});
    check("exception", res_exc, ex);
    @(posedge core_clk);
    check("writes", wr_q.size(), nw);
    check("monitor", mon_cnt, nm);
  endtask

  // Cuts a hung run short well past the expected length.
  initial begin
    repeat (5000) @(posedge core_clk);
    miscompares++;
    complete_run();
  end

  // Main sequence: reset, register port, then one trial per behaviour.
  initial begin
    logic [31:0] d;
    repeat (16) @(posedge core_clk);
    sys_rst <= 1'b0;
    @(posedge core_clk);
    reg_read(4'h0, d);
    check("cfg", d, 32'h3);
    reg_write(4'h4, 32'hFFFF_FFFF);
    reg_read(4'h4, d);
    check("status", d, 32'h0);
    reg_read(4'hC, d);
    check("unmapped", d, 32'h0);
    ev(0, 32'h140);
    reg_read(4'h4, d);
    check("link flag", d, 32'h1);
    reg_read(4'h8, d);
    check("link addr", d, 32'h140);
    trial(4, 32'h100, 0, 2'h0, 32'h104, 9'h1FC, 1, 0, 1, 0);
    check("word", wr_q[0], {1'b0, 32'h100, 32'h5A5A_C3C3});
    check("user map", user_seen, 1'b0);
    trial(4, 0, 0, 2'h0, 32'h100, 9'h0, 0, 0, 0, 0);
    trial(1, 32'h100, 0, 2'h0, 32'h100, 9'h0, 0, 0, 0, 0);
    trial(2, 32'h100, 0, 2'h0, 32'h100, 9'h0, 0, 0, 0, 0);
    trial(3, 32'h100, 32'h10C, 2'h0, 32'h100, 9'h0, 0, 0, 0, 0);
    trial(3, 32'h100, 32'h110, 2'h0, 32'h100, 9'h0, 1, 0, 1, 0);
    trial(4, 32'h100, 0, 2'h0, 32'h200, 9'h0, 0, 0, 0, 0);
    trial(4, 32'h100, 0, 2'h0, 32'h102, 9'h0, 0, 5, 0, 0);
    trial(4, 32'h100, 0, 2'h1, 32'h0FC, 9'h004, 1, 0, 1, 0);
    check("user map", user_seen, 1'b1);
    trial(4, 32'h108, 0, 2'h2, 32'h10C, 9'h0, 1, 0, 2, 0);
    check("low word", wr_q[0], {1'b1, 32'h108, 32'h5A5A_C3C3});
    check("high word", wr_q[1], {1'b1, 32'h10C, 32'hA5A5_3C3C});
    trial(4, 32'h100, 0, 2'h2, 32'h108, 9'h0, 0, 0, 0, 0);
    for (int e = 1; e < 5; e++) begin
      pm_exc <= 3'(e);
      trial(4, 32'h100, 0, 2'h1, 32'h100, 9'h0, 0, 3'(e), 0, 0);
    end
    pm_exc <= 3'h0;
    cs_cop_unusable <= 1'b1;
    trial(4, 32'h100, 0, 2'h1, 32'h100, 9'h0, 0, 7, 0, 0);
    cs_cop_unusable <= 1'b0;
    trial(4, 32'h100, 0, 2'h3, 32'h100, 9'h0, 0, 6, 0, 0);
    reg_write(4'h0, 32'h1);
    trial(4, 32'h100, 0, 2'h1, 32'h100, 9'h0, 0, 6, 0, 0);
    reg_write(4'h0, 32'h7);
    reg_read(4'h0, d);
    check("cfg", d, 32'h7);
    trial(4, 32'h108, 0, 2'h2, 32'h108, 9'h0, 0, 6, 0, 0);
    reg_write(4'h0, 32'h3);
    pm_unc <= 1'b1;
    pm_ok <= 1'b1;
    trial(4, 32'h100, 0, 2'h0, 32'h100, 9'h0, 1, 0, 0, 1);
    check("mon pair", pair_seen, 1'b0);
    trial(4, 32'h108, 0, 2'h2, 32'h108, 9'h0, 1, 0, 0, 1);
    check("mon pair", pair_seen, 1'b1);
    pm_ok <= 1'b0;
    trial(4, 32'h100, 0, 2'h0, 32'h100, 9'h0, 0, 0, 0, 1);
    reg_write(4'h0, 32'h2);
    pm_ok <= 1'b1;
    trial(4, 32'h100, 0, 2'h0, 32'h100, 9'h0, 0, 0, 0, 0);
    reg_write(4'h0, 32'h3);
    pm_unc <= 1'b0;
    pm_slow <= 1'b1;
    trial(4, 32'h108, 0, 2'h2, 32'h10C, 9'h0, 1, 0, 2, 0);
    trial(3, 32'h100, 32'h10C, 2'h0, 32'h100, 9'h0, 0, 0, 0, 0);
    complete_run();
  end
endmodule // store_conditional_unit_tb
